// [common/sarro_pkg.sv]
package sarro_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_MIN_NS   = 500;
  localparam int CONV_MAX_NS   = 1600;
  // least time rounds up, longest time rounds down
  localparam int CONV_MIN_CYC  = (CONV_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC  = CONV_MAX_NS / CLK_PERIOD_NS;

  localparam int WORD_W        = 16;
  localparam int CHAIN_DELAY   = 16;
  localparam int FIFO_DEPTH    = 4;
  localparam int EDGE_CNT_W    = 6;
  localparam int SYNC_STAGES   = 2;
  localparam int MSB_POS       = WORD_W - 1;

  localparam logic [15:0] RESULT_RST = 16'h0000;

  typedef enum logic [1:0] {
    SARRO_IDLE,
    SARRO_CONV,
    SARRO_HOLD
  } sarro_state_e;

endpackage : sarro_pkg

// [logic/sarro_fifo.sv]
`timescale 1ns/100ps
`default_nettype none

module sarro_fifo
  import sarro_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      fill_q;
  logic             push;
  logic             pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("sarro_fifo: DEPTH must be a power of two, at least 2");
    end
  end

  assign in_ready_o  = (fill_q != (AW+1)'(DEPTH));
  assign out_valid_o = (fill_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q   <= '0;
      rd_q   <= '0;
      fill_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        fill_q <= fill_q + 1'b1;
      end else if (pop && !push) begin
        fill_q <= fill_q - 1'b1;
      end
    end
  end

endmodule : sarro_fifo

`default_nettype wire

// [logic/sarro_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module sarro_sync
  import sarro_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) begin
      $error("sarro_sync: WIDTH must be at least 1");
    end
  end

  // meta_q is read by the second stage only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : sarro_sync

`default_nettype wire

// [logic/sarro_top.sv]
// Summary of operation
// - result is ready between 0.5 us and 1.6 us after convert_strobe rises
// - serial_out moves to the next bit after each falling serial clock
// - select mode: msb_bit driven once convert_strobe or serial_in is low
// - select mode: release serial_out on strobe/serial_in high or last bit
// - select mode: serial_in level caught at convert_strobe rising edge
// - chain mode: serial clock level caught at convert_strobe rise
// - chain mode: serial_in taken on each falling serial clock edge
// - chain mode with busy: serial_out goes high following serial_in high
// - serial_in low at strobe rise picks chain mode, high picks select
// - chain mode: serial_in reappears on serial_out 16 clocks later
// - each result is a 16-bit two's complement serial word
// - select mode busy enabled if serial_in or strobe low at completion
`timescale 1ns/100ps
`default_nettype none

module sarro_top
  import sarro_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        convert_strobe_i,
  input  wire logic        serial_in_i,
  input  wire logic        serial_clk_i,
  input  wire logic [15:0] adc_code_i,
  output logic             sample_o,
  output logic             conv_done_o,
  output logic             serial_out_o,
  output logic             serial_out_oe_o
);

  // system domain
  logic [2:0]          pin_s;
  logic                cnv_s;
  logic                sdi_s;
  logic                sclk_s;
  logic                cnv_d1_q;
  logic                cnv_rise;
  sarro_state_e        state_q;
  logic [4:0]          conv_cnt_q;
  logic                res_cap;
  logic [15:0]         res_q;
  logic                chain_q;
  logic                busy_en_q;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic [15:0]         fifo_out_data;
  logic                pop;
  logic [15:0]         word_q;
  logic                word_valid_q;
  logic                lead_q;
  logic [EDGE_CNT_W-1:0] base_q;
  logic [EDGE_CNT_W-1:0] gray_s;
  logic [EDGE_CNT_W-1:0] cnt_s;
  logic [EDGE_CNT_W-1:0] sent;
  logic                word_fin;
  logic                oe_q;

  // link domain, clocked by the host's serial clock
  logic [EDGE_CNT_W-1:0] edge_cnt_q;
  logic [EDGE_CNT_W-1:0] edge_gray_q;
  logic [EDGE_CNT_W-1:0] idx;
  logic [CHAIN_DELAY-1:0] chain_sr_q;
  logic                 out_bit;
  logic [4:0]           link_fill_q;

  initial begin
    if (CONV_MIN_CYC + SYNC_STAGES + 1 > CONV_MAX_CYC) begin
      $error("sarro_top: conversion window too short for sync latency");
    end
  end

  sarro_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk_i   (clk_sys_i),
    .rst_b_i (rst_b_i),
    .async_i ({convert_strobe_i, serial_in_i, serial_clk_i}),
    .sync_o  (pin_s)
  );

  assign cnv_s    = pin_s[2];
  assign sdi_s    = pin_s[1];
  assign sclk_s   = pin_s[0];
  assign cnv_rise = cnv_s && !cnv_d1_q;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnv_d1_q <= 1'b0;
    end else begin
      cnv_d1_q <= cnv_s;
    end
  end

  // conversion sequencer; a full FIFO holds the result back
  assign res_cap = (state_q == SARRO_CONV) &&
                   (conv_cnt_q == 5'(CONV_MIN_CYC - 1));

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q    <= SARRO_IDLE;
      conv_cnt_q <= '0;
    end else begin
      case (state_q)
        SARRO_IDLE: begin
          if (cnv_rise) begin
            state_q    <= SARRO_CONV;
            conv_cnt_q <= '0;
          end
        end
        SARRO_CONV: begin
          conv_cnt_q <= conv_cnt_q + 1'b1;
          if (res_cap) begin
            state_q <= SARRO_HOLD;
          end
        end
        SARRO_HOLD: begin
          if (fifo_in_ready) begin
            state_q <= SARRO_IDLE;
          end
        end
        default: begin
          state_q <= SARRO_IDLE;
        end
      endcase
    end
  end

  assign sample_o    = (state_q == SARRO_IDLE) && cnv_rise;
  assign conv_done_o = (state_q == SARRO_HOLD) && fifo_in_ready;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_q <= RESULT_RST;
    end else if (res_cap) begin
      res_q <= adc_code_i;
    end
  end

  // interface mode and chain busy option caught at the strobe edge, select busy option at completion
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chain_q   <= 1'b0;
      busy_en_q <= 1'b0;
    end else if (sample_o) begin
      chain_q   <= !sdi_s;
      busy_en_q <= !sdi_s && sclk_s;
    end else if (res_cap && !chain_q) begin
      busy_en_q <= !sdi_s || !cnv_s;
    end else if (chain_q && word_valid_q && word_fin) begin
      // busy pass-through ends with the own word; chained data follows
      busy_en_q <= 1'b0;
    end
  end

  sarro_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (state_q == SARRO_HOLD),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (res_q),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!word_valid_q),
    .out_data_o  (fifo_out_data)
  );

  // edge count from the link, gray coded so the crossing stays coherent
  sarro_sync #(
    .WIDTH (EDGE_CNT_W)
  ) u_cnt_sync (
    .clk_i   (clk_sys_i),
    .rst_b_i (rst_b_i),
    .async_i (edge_gray_q),
    .sync_o  (gray_s)
  );

  always_comb begin
    cnt_s = '0;
    for (int i = EDGE_CNT_W - 1; i >= 0; i--) begin
      cnt_s[i] = gray_s[i] ^ ((i == EDGE_CNT_W - 1) ? 1'b0 : cnt_s[i+1]);
    end
  end

  assign pop      = fifo_out_valid && !word_valid_q;
  assign sent     = cnt_s - base_q;
  assign word_fin = (sent >= EDGE_CNT_W'(WORD_W) + EDGE_CNT_W'(lead_q));

  // word and base count stay still while the host clocks the word out
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_q       <= RESULT_RST;
      word_valid_q <= 1'b0;
      lead_q       <= 1'b0;
      base_q       <= '0;
    end else if (pop) begin
      word_q       <= fifo_out_data;
      word_valid_q <= 1'b1;
      lead_q       <= busy_en_q;
      base_q       <= cnt_s;
    end else if (word_valid_q && word_fin) begin
      word_valid_q <= 1'b0;
    end
  end

  // enable is a flop on the system clock; turn-off lags the pins by ~3 cycles
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oe_q <= 1'b0;
    end else if (chain_q) begin
      oe_q <= 1'b1;
    end else begin
      oe_q <= (!cnv_s || !sdi_s) &&
              ((word_valid_q && !word_fin) ||
               (busy_en_q && state_q != SARRO_IDLE));
    end
  end

  assign serial_out_oe_o = oe_q;

  // link side: count falling edges and shift the chain path
  always_ff @(negedge serial_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      edge_cnt_q  <= '0;
      edge_gray_q <= '0;
    end else begin
      edge_cnt_q  <= edge_cnt_q + 1'b1;
      edge_gray_q <= (edge_cnt_q + 1'b1) ^ ((edge_cnt_q + 1'b1) >> 1);
    end
  end

  always_ff @(negedge serial_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chain_sr_q <= '0;
    end else begin
      chain_sr_q <= {chain_sr_q[CHAIN_DELAY-2:0], serial_in_i};
    end
  end

  // history depth seen by the chain delay check
  always_ff @(negedge serial_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_fill_q <= '0;
    end else if (link_fill_q != 5'(CHAIN_DELAY)) begin
      link_fill_q <= link_fill_q + 1'b1;
    end
  end

  // word_q, base_q and modes are quasi-static while the serial clock runs
  assign idx = edge_cnt_q - base_q;

  always_comb begin
    out_bit = 1'b0;
    if (!word_valid_q) begin
      if (chain_q) begin
        out_bit = busy_en_q ? sdi_s : chain_sr_q[CHAIN_DELAY-1];
      end
    end else if (idx < EDGE_CNT_W'(lead_q)) begin
      out_bit = chain_q ? sdi_s : 1'b1;
    end else if (idx < EDGE_CNT_W'(WORD_W) + EDGE_CNT_W'(lead_q)) begin
      out_bit = word_q[4'(MSB_POS) - 4'(idx - EDGE_CNT_W'(lead_q))];
    end else if (chain_q) begin
      out_bit = chain_sr_q[CHAIN_DELAY-1];
    end
  end

  assign serial_out_o = out_bit;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_start;
    (state_q == SARRO_IDLE) && cnv_rise;
  endsequence

  sequence s_convert;
    !res_cap [*4] ##1 res_cap;
  endsequence

  a_conv_time_min: assert property (
    s_start |=> s_convert
  ) else $error("conversion did not end after the least count");

  a_conv_done_by: assert property (
    s_start ##1 s_convert ##1 fifo_in_ready |-> conv_done_o
  ) else $error("conversion result not handed over");

  a_mode_select: assert property (
    s_start |=> (chain_q == !$past(sdi_s))
  ) else $error("interface mode not taken from serial_in");

  a_chain_busy_opt: assert property (
    s_start ##0 !sdi_s |=> (busy_en_q == $past(sclk_s))
  ) else $error("chain busy option not taken from clock level");

  a_sel_busy_opt: assert property (
    res_cap && !chain_q |=> (busy_en_q == $past(!sdi_s || !cnv_s))
  ) else $error("select busy option wrong at completion");

  a_oe_enable: assert property (
    !chain_q && (!cnv_s || !sdi_s) && word_valid_q && !word_fin
    |=> serial_out_oe_o
  ) else $error("serial_out not enabled in select mode");

  a_oe_release: assert property (
    !chain_q && cnv_s && sdi_s |=> !serial_out_oe_o
  ) else $error("serial_out not released in select mode");

  a_word_load: assert property (
    pop |=> word_valid_q && (word_q == $past(fifo_out_data))
  ) else $error("result word not loaded");

  a_chain_delay: assert property (
    @(negedge serial_clk_i) disable iff (!rst_b_i)
    link_fill_q == 5'(CHAIN_DELAY) |->
      chain_sr_q[CHAIN_DELAY-1] == $past(serial_in_i, 16)
  ) else $error("chain path delay is not 16 clocks");

endmodule : sarro_top

`default_nettype wire

// [tb/sarro_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

module sarro_host_model
  import sarro_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic serial_out_i,
  output logic      convert_strobe_o,
  output logic      serial_in_o,
  output logic      serial_clk_o
);

  initial begin
    convert_strobe_o = 1'b0;
    serial_in_o      = 1'b1;
    serial_clk_o     = 1'b0;
  end

  // serial_in picks the mode; the link clock stands still low meanwhile
  task automatic convert(input logic sel_hi, input int hold_ns);
    @(negedge clk_sys_i);
    serial_in_o      = sel_hi;
    @(negedge clk_sys_i);
    convert_strobe_o = 1'b1;
    #(hold_ns);
    convert_strobe_o = 1'b0;
  endtask : convert

  // 48 ns period, 24 ns phases; bit taken well before its falling edge
  task automatic shift(input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    dout = '0;
    for (int k = 0; k < n; k++) begin
      serial_in_o  = din[k];
      #12;
      serial_clk_o = 1'b1;
      #12;
      dout[k]      = serial_out_i;
      #12;
      serial_clk_o = 1'b0;
      #12;
    end
  endtask : shift

endmodule : sarro_host_model

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import sarro_pkg::*;

  logic        clk_sys_i;
  logic        rst_b_i;
  logic [15:0] adc_code_i;
  logic        strobe, ser_in, ser_clk, smp, done, ser_out, ser_oe;
  int          num_errors;
  int          compares;
  int          done_cnt;
  int          smp_cnt;
  realtime     t_rise;
  logic [15:0] wq [9];

  sarro_top u_dut (
    .clk_sys_i       (clk_sys_i),
    .rst_b_i         (rst_b_i),
    .convert_strobe_i(strobe),
    .serial_in_i     (ser_in),
    .serial_clk_i    (ser_clk),
    .adc_code_i      (adc_code_i),
    .sample_o        (smp),
    .conv_done_o     (done),
    .serial_out_o    (ser_out),
    .serial_out_oe_o (ser_oe)
  );

  sarro_host_model u_host (
    .clk_sys_i       (clk_sys_i),
    .serial_out_i    (ser_out),
    .convert_strobe_o(strobe),
    .serial_in_o     (ser_in),
    .serial_clk_o    (ser_clk)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // pulses are launched on the rising edge, so count them on the falling one
  always @(negedge clk_sys_i) begin
    if (done === 1'b1) done_cnt++;
    if (smp === 1'b1) smp_cnt++;
  end

  always @(posedge strobe) t_rise = $realtime;

  function automatic logic [31:0] mask(int n);
    return (32'h1 << n) - 32'h1;
  endfunction : mask

  // busy bit first when enabled, word MSB first, then the chained bits
  function automatic logic [31:0] expect_bits(logic [15:0] w, logic busy,
                                              logic [15:0] tail);
    logic [31:0] e;
    int          o;
    e = '0;
    o = busy;
    for (int k = 0; k < 16; k++) begin
      e[k + o]      = w[15 - k];
      e[k + 16 + o] = tail[k];
    end
    if (busy) e[0] = 1'b1;
    return e;
  endfunction : expect_bits

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic start_conv(input logic [15:0] w, input logic sel,
                            input int hold);
    @(negedge clk_sys_i);
    adc_code_i = w;
    u_host.convert(sel, hold);
  endtask : start_conv

  task automatic read_sel(input logic [15:0] w, input logic busy,
                          input logic more);
    logic [31:0] got;
    int          n;
    n = 16 + busy;
    #500;
    check("oe_on", ser_oe, 1'b1);
    u_host.shift(n, 32'hFFFFFFFF, got);
    check("word", got & mask(n),
          expect_bits(w, busy, 16'h0) & mask(n));
    // a queued word is presented again at once while the strobe stays low
    #600;
    check("oe_after", ser_oe, more);
  endtask : read_sel

  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end

  initial begin
    logic [31:0] got;
    logic [31:0] din;
    int          base;
    realtime     lat;
    void'($urandom(32'h4AF6E9BC));
    rst_b_i    = 1'b0;
    adc_code_i = 16'h0000;
    repeat (10) @(negedge clk_sys_i);
    check("oe_rst", ser_oe, 1'b0);
    check("done_rst", done, 1'b0);
    repeat (2) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    // strobe low before completion, so the busy bit leads the word
    start_conv(16'h8000, 1'b1, 300);
    for (int i = 0; i < 30 && done !== 1'b1; i++) @(negedge clk_sys_i);
    lat = $realtime - t_rise;
    check("t_conv", lat >= CONV_MIN_NS && lat <= CONV_MAX_NS + 50,
          1'b1);
    read_sel(16'h8000, 1'b1, 1'b0);
    // chain mode: own word, then serial_in delayed by 16 clocks
    din = $urandom;
    start_conv(16'h7FFF, 1'b0, 1200);
    #500;
    check("chain_oe", ser_oe, 1'b1);
    u_host.shift(32, din, got);
    check("chain", got,
          expect_bits(16'h7FFF, 1'b0, din[15:0]));
    // output word plus four buffered words; the sixth result waits in hold
    for (int i = 0; i < 9; i++) wq[i] = (i < 2) ? {16{i[0]}} : 16'($urandom);
    base = done_cnt;
    for (int i = 0; i < 6; i++) begin
      start_conv(wq[i], 1'b1, 1200);
      #800;
    end
    check("fifo_full", done_cnt - base, 5);
    check("samples", smp_cnt, 8);
    for (int i = 0; i < 9; i++) begin
      read_sel(wq[i], 1'b0, i < 8);
      if (i < 3) begin
        start_conv(wq[i + 6], 1'b1, 1200);
        #800;
      end
    end
    check("done_all", done_cnt - base, 9);
    end_of_test();
  end

endmodule : testbench

`default_nettype wire
